// file: rtl/sxt_exec.sv
// Execution unit for nibble swap, skips, table reads and xor
`timescale 1ns/10ps
`include "sxt_cfg.svh"

module sxt_exec
    import sxt_pkg::*;
#(
    parameter int DATA_W = `SXT_DATA_W,
    parameter int ROM_W = `SXT_ROM_W,
    parameter int ROM_AW = `SXT_ROM_AW,
    parameter int PAGE_W = `SXT_PAGE_W
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Instruction issue
    input wire logic ISSUE_VALID,
    input wire logic [`SXT_OP_W-1:0] OPCODE,
    input wire logic [DATA_W-1:0] MEM_OPERAND,
    input wire logic [DATA_W-1:0] LITERAL,
    input wire logic [`SXT_BIT_W-1:0] BIT_SEL,
    input wire logic [ROM_AW-1:0] CUR_PC,
    input wire logic [PAGE_W-1:0] ROM_TABLE_INDEX,
    output logic ISSUE_READY,
    // Program ROM read port, data must be valid in the same cycle as the request
    output logic ROM_RD,
    output logic [ROM_AW-1:0] ROM_ADDR,
    input wire logic [ROM_W-1:0] ROM_DATA,
    // Results
    output logic [DATA_W-1:0] ACC,
    output logic ZERO_FLAG,
    output logic [ROM_W-DATA_W-1:0] TABLE_HIGH_LATCH,
    output logic MEM_WE,
    output logic [DATA_W-1:0] MEM_WDATA,
    output logic DISCARD_PREFETCH,
    output logic DONE
);

    localparam int HI_W = ROM_W - DATA_W;
    localparam int NIB_W = DATA_W / 2;
    localparam int PAGE_HI_W = ROM_AW - PAGE_W;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == DATA_W'(`SXT_ZERO_BYTE));
    endfunction

    // Skip test of the three variants; none of them writes the byte
    function automatic logic skip_hit(
        input logic [`SXT_OP_W-1:0] op,
        input logic [DATA_W-1:0] v,
        input logic [`SXT_BIT_W-1:0] sel
    );
        case (op)
            `SXT_OP_SKIP_ZERO: skip_hit = is_zero(v);
            `SXT_OP_COPY_SKIP: skip_hit = is_zero(v);
            `SXT_OP_BIT_SKIP: skip_hit = !v[sel];
            default: skip_hit = 1'b0;
        endcase
    endfunction

    function automatic logic is_table_op(input logic [`SXT_OP_W-1:0] op);
        is_table_op = (op == `SXT_OP_TRD_CUR) || (op == `SXT_OP_TRD_LAST);
    endfunction

    function automatic logic is_xor_op(input logic [`SXT_OP_W-1:0] op);
        is_xor_op = (op == `SXT_OP_XOR_A) || (op == `SXT_OP_XOR_M) || (op == `SXT_OP_XOR_X);
    endfunction

    // Upper address bits select the page, the index picks the word
    function automatic logic [ROM_AW-1:0] table_addr(
        input logic [PAGE_HI_W-1:0] page,
        input logic [PAGE_W-1:0] index
    );
        table_addr = {page, index};
    endfunction

    // Issue decode
    logic take;
    logic skip_now;
    logic op_xor_mem;
    logic op_xor_imm;
    logic op_trd_cur;
    logic op_trd_last;
    logic [DATA_W-1:0] xor_operand;
    logic [DATA_W-1:0] xor_res;

    // Sequencer
    sxt_state_e state_ff;
    sxt_state_e nxt_state;
    logic discard_ff;
    logic nxt_discard;
    logic done_ff;
    logic nxt_done;

    // Accumulator and zero flag
    logic [DATA_W-1:0] acc_ff;
    logic [DATA_W-1:0] nxt_acc;
    logic zero_ff;
    logic nxt_zero;

    // Data memory write
    logic we_ff;
    logic nxt_we;
    logic [DATA_W-1:0] wdata_ff;
    logic [DATA_W-1:0] nxt_wdata;

    // ROM request and high latch
    logic rd_ff;
    logic nxt_rd;
    logic [ROM_AW-1:0] raddr_ff;
    logic [ROM_AW-1:0] nxt_raddr;
    logic [HI_W-1:0] hi_ff;
    logic [HI_W-1:0] nxt_hi;

    // ------------------------------------------------------------
    // Issue decode
    // ------------------------------------------------------------
    always_comb begin
        take = ISSUE_VALID && (state_ff == SXT_EXEC);
        skip_now = take && skip_hit(OPCODE, MEM_OPERAND, BIT_SEL);
        op_xor_mem = take && (OPCODE == `SXT_OP_XOR_M);
        op_xor_imm = take && (OPCODE == `SXT_OP_XOR_X);
        op_trd_cur = take && (OPCODE == `SXT_OP_TRD_CUR);
        op_trd_last = take && (OPCODE == `SXT_OP_TRD_LAST);
        // One xor datapath serves all three forms
        xor_operand = op_xor_imm ? LITERAL : MEM_OPERAND;
        xor_res = acc_ff ^ xor_operand;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Issue is refused during the extra cycle, so nothing lands in it
    always_comb begin
        nxt_state = state_ff;
        nxt_discard = 1'b0;
        nxt_done = 1'b0;
        case (state_ff)
            SXT_EXEC: begin
                if (skip_now) begin
                    // Prefetched word is dropped, dummy cycle follows
                    nxt_discard = 1'b1;
                    nxt_state = SXT_DUMMY;
                end else if (take && is_table_op(OPCODE)) begin
                    nxt_state = SXT_ROM_WAIT;
                end else if (take) begin
                    nxt_done = 1'b1;
                end
            end
            SXT_ROM_WAIT: begin
                nxt_done = 1'b1;
                nxt_state = SXT_EXEC;
            end
            SXT_DUMMY: begin
                nxt_done = 1'b1;
                nxt_state = SXT_EXEC;
            end
            default: begin
                nxt_state = SXT_EXEC;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_ff <= SXT_EXEC;
            discard_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            discard_ff <= nxt_discard;
            done_ff <= nxt_done;
        end
    end

    // ------------------------------------------------------------
    // Accumulator and zero flag
    // ------------------------------------------------------------
    always_comb begin
        nxt_acc = acc_ff;
        nxt_zero = zero_ff;
        if (take) begin
            case (OPCODE)
                `SXT_OP_SWAP_ACC: begin
                    nxt_acc = {MEM_OPERAND[NIB_W-1:0], MEM_OPERAND[DATA_W-1:NIB_W]};
                end
                `SXT_OP_COPY_SKIP: begin
                    nxt_acc = MEM_OPERAND;
                end
                `SXT_OP_XOR_A: begin
                    nxt_acc = xor_res;
                end
                `SXT_OP_XOR_X: begin
                    nxt_acc = xor_res;
                end
                default: begin
                    nxt_acc = acc_ff;
                end
            endcase
            // Swap, skips and table reads leave the flag alone
            if (is_xor_op(OPCODE)) begin
                nxt_zero = is_zero(xor_res);
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            acc_ff <= DATA_W'(`SXT_ACC_RST);
            zero_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            zero_ff <= nxt_zero;
        end
    end

    // ------------------------------------------------------------
    // Data memory write
    // ------------------------------------------------------------
    // No collision: a take only happens outside the ROM wait state
    always_comb begin
        nxt_we = 1'b0;
        nxt_wdata = wdata_ff;
        if (op_xor_mem) begin
            nxt_we = 1'b1;
            nxt_wdata = xor_res;
        end else if (state_ff == SXT_ROM_WAIT) begin
            nxt_we = 1'b1;
            nxt_wdata = ROM_DATA[DATA_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            we_ff <= 1'b0;
            wdata_ff <= DATA_W'(`SXT_ZERO_BYTE);
        end else begin
            we_ff <= nxt_we;
            wdata_ff <= nxt_wdata;
        end
    end

    // ------------------------------------------------------------
    // ROM request and high latch
    // ------------------------------------------------------------
    // ROM must answer in the same cycle as the request; no wait states
    always_comb begin
        nxt_rd = 1'b0;
        nxt_raddr = raddr_ff;
        nxt_hi = hi_ff;
        if (op_trd_cur) begin
            // Page bits from the program counter, offset from the index
            nxt_raddr = table_addr(CUR_PC[ROM_AW-1:PAGE_W], ROM_TABLE_INDEX);
            nxt_rd = 1'b1;
        end else if (op_trd_last) begin
            nxt_raddr = table_addr({PAGE_HI_W{1'b1}}, ROM_TABLE_INDEX);
            nxt_rd = 1'b1;
        end
        if (state_ff == SXT_ROM_WAIT) begin
            // Latch takes the upper part whatever the memory destination
            nxt_hi = ROM_DATA[ROM_W-1:DATA_W];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rd_ff <= 1'b0;
            raddr_ff <= '0;
            hi_ff <= HI_W'(`SXT_HI_RST);
        end else begin
            rd_ff <= nxt_rd;
            raddr_ff <= nxt_raddr;
            hi_ff <= nxt_hi;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ISSUE_READY = (state_ff == SXT_EXEC);
    assign ROM_RD = rd_ff;
    assign ROM_ADDR = raddr_ff;
    assign ACC = acc_ff;
    assign ZERO_FLAG = zero_ff;
    assign TABLE_HIGH_LATCH = hi_ff;
    assign MEM_WE = we_ff;
    assign MEM_WDATA = wdata_ff;
    assign DISCARD_PREFETCH = discard_ff;
    assign DONE = done_ff;

endmodule

// file: rtl/sxt_cfg.svh
// Constants for the skip, xor and table-read execution unit
`ifndef SXT_CFG_SVH
`define SXT_CFG_SVH
`define SXT_DATA_W 8
`define SXT_ROM_W 15
`define SXT_ROM_AW 12
`define SXT_PAGE_W 8
`define SXT_HI_W 7
`define SXT_BIT_W 3
`define SXT_OP_W 4
`define SXT_OP_NOP 4'h0
`define SXT_OP_SWAP_ACC 4'h1
`define SXT_OP_SKIP_ZERO 4'h2
`define SXT_OP_COPY_SKIP 4'h3
`define SXT_OP_BIT_SKIP 4'h4
`define SXT_OP_TRD_CUR 4'h5
`define SXT_OP_TRD_LAST 4'h6
`define SXT_OP_XOR_A 4'h7
`define SXT_OP_XOR_M 4'h8
`define SXT_OP_XOR_X 4'h9
`define SXT_ACC_RST 8'h00
`define SXT_HI_RST 7'h00
`define SXT_ZERO_BYTE 8'h00
`endif

// file: rtl/sxt_pkg.sv
// Types for the skip, xor and table-read execution unit
package sxt_pkg;
    typedef enum logic [1:0] {SXT_EXEC, SXT_ROM_WAIT, SXT_DUMMY} sxt_state_e;
endpackage

// file: bench/sxt_exec_assertions.sv
// Port assertions for the skip, xor and table-read execution unit
`timescale 1ns/10ps
module sxt_chk (
    // Strobes and flags
    input wire logic REF_CLK, RST, ISSUE_VALID, ISSUE_READY, ROM_RD, MEM_WE, DISCARD_PREFETCH, DONE, ZERO_FLAG,
    // Operands and results
    input wire logic [3:0] OPCODE,
    input wire logic [2:0] BIT_SEL,
    input wire logic [7:0] MEM_OPERAND, LITERAL, ROM_TABLE_INDEX, ACC, MEM_WDATA,
    input wire logic [11:0] CUR_PC, ROM_ADDR,
    input wire logic [14:0] ROM_DATA,
    input wire logic [6:0] TABLE_HIGH_LATCH
);
    wire take = ISSUE_VALID && ISSUE_READY;
    wire is_trd = OPCODE == 4'h5 || OPCODE == 4'h6;
    wire sel_bit = MEM_OPERAND[BIT_SEL];
    wire [3:0] cur_page = CUR_PC[11:8];
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // ----------------
    // Checks tied to each taken issue
    // ----------------
    dummy_cycle_a:
        assert property (take ##1 DISCARD_PREFETCH |-> !ISSUE_READY && !DONE ##1 DONE && ISSUE_READY)
        else $error("dummy cycle wrong");
    zero_skip_a:
        assert property (take && OPCODE == 4'h2 |=> DISCARD_PREFETCH == ($past(MEM_OPERAND) == 8'h00) && !MEM_WE)
        else $error("byte skip wrong");
    copy_skip_a:
        assert property (take && OPCODE == 4'h3 |=> ACC == $past(MEM_OPERAND) && DISCARD_PREFETCH == (ACC == 8'h00))
        else $error("copy skip wrong");
    bit_skip_a:
        assert property (take && OPCODE == 4'h4 |=> DISCARD_PREFETCH == !$past(sel_bit))
        else $error("bit skip wrong");
    nibble_swap_a:
        assert property (take && OPCODE == 4'h1 |=> {ACC[3:0], ACC[7:4]} == $past(MEM_OPERAND) && !MEM_WE)
        else $error("swap wrong");
    table_addr_a:
        assert property (take && is_trd |=> ROM_RD && ROM_ADDR ==
            {($past(OPCODE) == 4'h6) ? 4'hF : $past(cur_page), $past(ROM_TABLE_INDEX)}) else $error("rom addr wrong");
    table_store_a:
        assert property (take && is_trd ##1 1'b1 |=> MEM_WE && DONE && {TABLE_HIGH_LATCH, MEM_WDATA} == $past(ROM_DATA))
        else $error("table store wrong");
    xor_acc_a:
        assert property (take && (OPCODE == 4'h7 || OPCODE == 4'h9) |=> ZERO_FLAG == (ACC == 8'h00) && ACC ==
            ($past(ACC) ^ (($past(OPCODE) == 4'h7) ? $past(MEM_OPERAND) : $past(LITERAL)))) else $error("xor acc wrong");
    xor_mem_a:
        assert property (take && OPCODE == 4'h8 |=> MEM_WE && MEM_WDATA == ($past(ACC) ^ $past(MEM_OPERAND))
            && $stable(ACC) && ZERO_FLAG == (MEM_WDATA == 8'h00)) else $error("xor mem wrong");
    flags_kept_a:
        assert property (take && OPCODE inside {[4'h1:4'h6]} |=> $stable(ZERO_FLAG)) else $error("flag moved");
endmodule
bind sxt_exec sxt_chk chk_i (.*);

// file: bench/tb_top.sv
// Self-checking bench for the execution unit
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, valid = 1'b0;
    logic [3:0] op = 4'h0;
    logic [2:0] bsel = 3'h0;
    logic [7:0] mem = 8'h00, lit = 8'h00, idx = 8'h00, acc, wdata;
    logic [11:0] pc = 12'h000, raddr;
    logic [14:0] rdata = 15'h0000;
    logic [6:0] hi;
    logic ready, rrd, we, disc, done, zf;
    int n_mismatch = 0, checks_done = 0, cycles = 0;
    sxt_exec uut (.REF_CLK(ref_clk), .RST(rst), .ISSUE_VALID(valid), .OPCODE(op), .MEM_OPERAND(mem),
        .LITERAL(lit), .BIT_SEL(bsel), .CUR_PC(pc), .ROM_TABLE_INDEX(idx), .ISSUE_READY(ready), .ROM_RD(rrd),
        .ROM_ADDR(raddr), .ROM_DATA(rdata), .ACC(acc), .ZERO_FLAG(zf), .TABLE_HIGH_LATCH(hi), .MEM_WE(we),
        .MEM_WDATA(wdata), .DISCARD_PREFETCH(disc), .DONE(done));
    always #2.5 ref_clk = ~ref_clk;
    // Whole run needs well under 100 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Returns half a cycle after the take; operand is scrambled once released
    task automatic iss(input logic [3:0] o, input logic [7:0] m, input logic [7:0] l, input logic [2:0] b);
        @(negedge ref_clk);
        valid = 1'b1;
        op = o;
        mem = m;
        lit = l;
        bsel = b;
        @(negedge ref_clk);
        valid = 1'b0;
        mem = ~m;
    endtask
    task automatic t_xor();
        iss(4'h3, 8'h5A, 8'h00, 3'h0);
        chk("copy", {acc, disc, done}, {8'h5A, 2'b01});
        iss(4'h7, 8'h5A, 8'h00, 3'h0);
        chk("xor acc", {acc, zf}, {8'h00, 1'b1});
        iss(4'h9, 8'h00, 8'h3C, 3'h0);
        chk("xor imm", {acc, zf}, {8'h3C, 1'b0});
        iss(4'h8, 8'h3C, 8'h00, 3'h0);
        chk("xor mem", {we, wdata, acc, zf}, {1'b1, 8'h00, 8'h3C, 1'b1});
    endtask
    task automatic t_swap();
        iss(4'h1, 8'hA5, 8'h00, 3'h0);
        chk("swap", {acc, we, zf}, {8'h5A, 1'b0, 1'b1});
        iss(4'h0, 8'h00, 8'h00, 3'h0);
        chk("nop", {acc, zf, we, done, disc}, {8'h5A, 1'b1, 1'b0, 1'b1, 1'b0});
    endtask
    // Entries: taken, opcode, byte, bit; a nonzero byte with a clear bit must still skip
    task automatic t_skip();
        logic [15:0] cs [5] = '{{1'b1, 4'h2, 8'h00, 3'h0}, {1'b0, 4'h2, 8'h01, 3'h0},
            {1'b1, 4'h3, 8'h00, 3'h0}, {1'b1, 4'h4, 8'h7F, 3'h7}, {1'b0, 4'h4, 8'hFE, 3'h1}};
        for (int i = 0; i < 5; i++) begin
            iss(cs[i][14:11], cs[i][10:3], 8'h00, cs[i][2:0]);
            chk("skip c1", {disc, done, ready}, {cs[i][15], !cs[i][15], !cs[i][15]});
            @(negedge ref_clk);
            chk("skip c2", {disc, done, ready, zf}, {1'b0, cs[i][15], 2'b11});
        end
    endtask
    task automatic t_table(input logic [3:0] o, input logic [11:0] a, input logic [14:0] d);
        pc = 12'h3AB;
        idx = 8'h12;
        iss(o, 8'h00, 8'h00, 3'h0);
        chk("rom req", {rrd, raddr, ready}, {1'b1, a, 1'b0});
        rdata = d;
        @(negedge ref_clk);
        rdata = ~d;
        chk("table", {we, hi, wdata, done, zf}, {1'b1, d, 2'b11});
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_xor();
        t_swap();
        t_skip();
        t_table(4'h5, 12'h312, 15'h5A96);
        t_table(4'h6, 12'hF12, 15'h2B4C);
        give_verdict();
    end
endmodule
